// ### hdl/nss_pkg.sv
// Shared constants for the node setup strap decoder.
// Assumes a single 100 MHz system clock and a word-indexed register port.
package nss_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned PRIO_UNIT_NS     = 146000;  // Per-ID priority step at 2.5 Mbps
  localparam int unsigned PRIO_UNIT_CYC    = PRIO_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned MCLK_FAST_KHZ    = 40000;   // Master clock that yields 5 Mbps
  localparam int unsigned MCLK_DEF_KHZ     = 20000;

  // Register indices (word addresses)
  localparam logic [3:0] REG_MODE          = 4'h0;
  localparam logic [3:0] REG_PAGE          = 4'h1;
  localparam logic [3:0] REG_TOP_ID        = 4'h2;
  localparam logic [3:0] REG_OWN_ID        = 4'h3;
  localparam logic [3:0] REG_PRESCALE      = 4'h4;
  localparam logic [3:0] REG_STATUS        = 4'h5;

  // Mode register fields
  localparam int unsigned MODE_SRC_MAIN_BIT = 9;      // Page, top ID, prescale source
  localparam int unsigned MODE_SRC_ID_BIT   = 7;      // Own ID source

  // Status register fields
  localparam int unsigned ST_OWN_VALID_BIT  = 15;
  localparam int unsigned ST_INITIATOR_BIT  = 14;
  localparam int unsigned ST_RSVD_RATE_BIT  = 13;
  localparam int unsigned ST_FAST_RATE_BIT  = 12;
  localparam int unsigned ST_DIAG_BIT       = 11;
  localparam int unsigned ST_PRESCALE_LSB   = 8;
  localparam int unsigned ST_PAGE_LSB       = 5;
  localparam int unsigned ST_TOP_LSB        = 0;

  // Reset values
  localparam logic [15:0] MODE_RST         = 16'h0000;
  localparam logic [1:0]  PAGE_RST         = 2'h0;
  localparam logic [4:0]  TOP_ID_RST       = 5'h00;
  localparam logic [4:0]  OWN_ID_RST       = 5'h00;
  localparam logic [2:0]  PRESCALE_RST     = 3'h0;

  // Node ID limits
  localparam logic [4:0]  ID_NONE          = 5'h00;
  localparam logic [4:0]  ID_DIAG_TOP      = 5'h1F;
  localparam logic [4:0]  ID_PRIO_BASE     = 5'h1F;   // Priority slots = base minus own ID

  // Page size codes
  localparam logic [1:0]  PAGE_256         = 2'h0;
  localparam logic [1:0]  PAGE_128         = 2'h1;
  localparam logic [1:0]  PAGE_64          = 2'h2;
  localparam logic [1:0]  PAGE_32          = 2'h3;

  // Prescale codes
  localparam logic [2:0]  PRESCALE_MAX     = 3'h5;    // Above this is reserved
  localparam logic [2:0]  PRESCALE_FAST    = 3'h0;
  localparam logic [8:0]  PRESCALE_BASE    = 9'h008;

  typedef enum logic [1:0] {PW_IDLE, PW_UNIT, PW_DONE} nss_prio_state_t;

endpackage : nss_pkg

// ### hdl/nss_strap_decoder.sv
// Node setup strap decoder: straps, register alternatives, derived controls.
// Assumes board straps, the host strobe and the port 2 receive pin are asynchronous; all else on clk_sys.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module nss_strap_decoder
  import nss_pkg::*;
#(
  parameter int unsigned MCLK_KHZ      = MCLK_DEF_KHZ,
  parameter int unsigned PRIO_UNIT_CYCLES = PRIO_UNIT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Board straps
  input  wire logic        strobe_polarity_strap,
  input  wire logic [1:0]  page_size_strap,
  input  wire logic [4:0]  top_node_id_strap,
  input  wire logic [4:0]  own_node_id_strap,
  input  wire logic        diagnostic_strap_n,
  input  wire logic [2:0]  rate_prescale_strap,
  input  wire logic        line_code_bypass_n,
  input  wire logic        hub_enable_n,
  input  wire logic        optical_mode_n,
  input  wire logic        tx_enable_polarity,
  // Host strobe and port pins
  input  wire logic        host_data_strobe,
  input  wire logic        port2_rx_in,
  // Protocol engine side
  input  wire logic        port1_tx_req,
  input  wire logic        port2_tx_req,
  input  wire logic        tx_pulse,
  input  wire logic [4:0]  token_target_id,
  input  wire logic        prio_wait_start,
  // Decoded controls
  output logic             strobe_asserted,
  output logic      [8:0]  page_bytes,
  output logic      [4:0]  max_nodes,
  output logic      [4:0]  top_node_id,
  output logic      [4:0]  own_node_id,
  output logic             own_id_valid,
  output logic             token_initiator,
  output logic             token_target_ok,
  output logic             prio_wait_busy,
  output logic             prio_wait_done,
  output logic             bit_tick,
  output logic             rate_reserved,
  output logic             cmi_bypass,
  output logic             hub_on,
  output logic             port2_rx_data,
  output logic             port1_tx_enable,
  output logic             port2_tx_enable
);

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins from outside the clock domain
  localparam int unsigned SYNC_W = 23;
  logic [SYNC_W-1:0] pin_meta_q;
  logic [SYNC_W-1:0] pin_sync_q;
  wire  [SYNC_W-1:0] pin_raw = {host_data_strobe, port2_rx_in, strobe_polarity_strap,
                                page_size_strap, top_node_id_strap, own_node_id_strap,
                                diagnostic_strap_n, rate_prescale_strap, line_code_bypass_n,
                                hub_enable_n, optical_mode_n, tx_enable_polarity};

  // Not reset so the straps settle while reset is held
  always_ff @(posedge clk_sys) begin
    pin_meta_q <= pin_raw;
    pin_sync_q <= pin_meta_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture: frozen outside reset so a wobbling pin cannot retune the node
  logic [20:0] strap_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strap_q <= pin_sync_q[20:0];
    end
  end

  wire       s_strobe_pol = strap_q[20];
  wire [1:0] s_page       = strap_q[19:18];
  wire [4:0] s_top        = strap_q[17:13];
  wire [4:0] s_own        = strap_q[12:8];
  wire       s_diag_n     = strap_q[7];
  wire [2:0] s_prescale   = strap_q[6:4];
  wire       s_bypass_n   = strap_q[3];
  wire       s_hub_n      = strap_q[2];
  wire       s_optical_n  = strap_q[1];
  wire       s_tx_pol     = strap_q[0];
  wire       strobe_sync  = pin_sync_q[22];
  wire       rx2_sync     = pin_sync_q[21];

  //////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [15:0] mode_q;
  logic [1:0]  page_q;
  logic [4:0]  top_q;
  logic [4:0]  own_q;
  logic [2:0]  prescale_q;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q     <= MODE_RST;
      page_q     <= PAGE_RST;
      top_q      <= TOP_ID_RST;
      own_q      <= OWN_ID_RST;
      prescale_q <= PRESCALE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_MODE:     mode_q     <= reg_wdata;
        REG_PAGE:     page_q     <= reg_wdata[1:0];
        REG_TOP_ID:   top_q      <= reg_wdata[4:0];
        REG_OWN_ID:   own_q      <= reg_wdata[4:0];
        REG_PRESCALE: prescale_q <= reg_wdata[2:0];
        default:      ;  // Unmapped and read-only writes are dropped
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Source selection
  wire       src_main = mode_q[MODE_SRC_MAIN_BIT];
  wire       src_id   = mode_q[MODE_SRC_ID_BIT];
  wire [1:0] page_d   = src_main ? page_q : s_page;
  wire [4:0] top_sel  = src_main ? top_q : s_top;
  wire [4:0] top_d    = !s_diag_n ? ID_DIAG_TOP : top_sel;
  wire [4:0] own_d    = src_id ? own_q : s_own;
  wire [2:0] presc_d  = src_main ? prescale_q : s_prescale;
  wire       rsvd_d   = presc_d > PRESCALE_MAX;
  wire       fast_d   = (presc_d == PRESCALE_FAST) && (MCLK_KHZ == MCLK_FAST_KHZ);

  // Page size decode
  logic [8:0] page_bytes_d;
  logic [4:0] max_nodes_d;
  always_comb begin
    case (page_d)
      PAGE_256: {page_bytes_d, max_nodes_d} = {9'h100, 5'h03};
      PAGE_128: {page_bytes_d, max_nodes_d} = {9'h080, 5'h07};
      PAGE_64:  {page_bytes_d, max_nodes_d} = {9'h040, 5'h0F};
      default:  {page_bytes_d, max_nodes_d} = {9'h020, 5'h1F};
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered configuration outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      page_bytes      <= 9'h000;
      max_nodes       <= 5'h00;
      top_node_id     <= ID_NONE;
      own_node_id     <= ID_NONE;
      own_id_valid    <= 1'b0;
      token_initiator <= 1'b0;
      token_target_ok <= 1'b0;
      rate_reserved   <= 1'b0;
      cmi_bypass      <= 1'b0;
      hub_on          <= 1'b0;
      strobe_asserted <= 1'b0;
    end else begin
      page_bytes      <= page_bytes_d;
      max_nodes       <= max_nodes_d;
      top_node_id     <= top_d;
      own_node_id     <= own_d;
      own_id_valid    <= (own_d != ID_NONE) && (own_d <= top_d);
      token_initiator <= (own_d == top_d);
      token_target_ok <= (token_target_id != ID_NONE) && (token_target_id <= top_d);
      rate_reserved   <= rsvd_d;
      cmi_bypass      <= !s_bypass_n;
      hub_on          <= !s_hub_n;
      strobe_asserted <= s_strobe_pol ? !strobe_sync : strobe_sync;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bit-rate prescaler; reserved codes stop the tick rather than guess a rate
  logic [7:0] div_cnt_q;
  wire  [8:0] div_len = PRESCALE_BASE << presc_d;

  always_ff @(posedge clk_sys) begin
    if (reset || rsvd_d) begin
      div_cnt_q <= 8'h00;
      bit_tick  <= 1'b0;
    end else if ({1'b0, div_cnt_q} == div_len - 9'h001) begin
      div_cnt_q <= 8'h00;
      bit_tick  <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
      bit_tick  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reconfiguration priority wait
  localparam logic [15:0] UNIT_SLOW = 16'(PRIO_UNIT_CYCLES);
  localparam logic [15:0] UNIT_FAST = 16'(PRIO_UNIT_CYCLES / 2);
  nss_prio_state_t pw_state_q;
  logic [15:0]     unit_cnt_q;
  logic [4:0]      slot_cnt_q;
  wire  [15:0]     unit_len = fast_d ? UNIT_FAST : UNIT_SLOW;

  // Unit length follows the rate live; a rate change mid-wait stretches one step
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pw_state_q <= PW_IDLE;
      unit_cnt_q <= 16'h0000;
      slot_cnt_q <= 5'h00;
    end else begin
      case (pw_state_q)
        PW_IDLE: begin
          if (prio_wait_start) begin
            unit_cnt_q <= 16'h0000;
            slot_cnt_q <= ID_PRIO_BASE - own_d;
            pw_state_q <= (own_d == ID_PRIO_BASE) ? PW_DONE : PW_UNIT;
          end
        end
        PW_UNIT: begin
          if (unit_cnt_q == unit_len - 16'h0001) begin
            unit_cnt_q <= 16'h0000;
            slot_cnt_q <= slot_cnt_q - 5'h01;
            if (slot_cnt_q == 5'h01) begin
              pw_state_q <= PW_DONE;
            end
          end else begin
            unit_cnt_q <= unit_cnt_q + 16'h0001;
          end
        end
        PW_DONE: pw_state_q <= PW_IDLE;
        default: pw_state_q <= PW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prio_wait_busy <= 1'b0;
      prio_wait_done <= 1'b0;
    end else begin
      prio_wait_busy <= (pw_state_q == PW_UNIT);
      prio_wait_done <= (pw_state_q == PW_DONE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit enables and second port
  wire tx1_act = s_optical_n ? port1_tx_req : (port1_tx_req & tx_pulse);
  wire tx2_raw = s_optical_n ? port2_tx_req : (port2_tx_req & tx_pulse);
  wire tx2_act = tx2_raw & !s_hub_n;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port1_tx_enable <= 1'b0;
      port2_tx_enable <= 1'b0;
      port2_rx_data   <= 1'b1;
    end else begin
      port1_tx_enable <= s_tx_pol ? tx1_act : !tx1_act;
      port2_tx_enable <= s_tx_pol ? tx2_act : !tx2_act;
      port2_rx_data   <= s_hub_n ? 1'b1 : rx2_sync;      // Idle high when hub is off
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path: data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk_sys) begin
    if (reset || !reg_rd) begin
      reg_rdata <= 16'h0000;
    end else begin
      case (reg_addr)
        REG_MODE:     reg_rdata <= mode_q;
        REG_PAGE:     reg_rdata <= {14'h0000, page_q};
        REG_TOP_ID:   reg_rdata <= {11'h000, top_q};
        REG_OWN_ID:   reg_rdata <= {11'h000, own_q};
        REG_PRESCALE: reg_rdata <= {13'h0000, prescale_q};
        REG_STATUS: begin
          reg_rdata                   <= 16'h0000;
          reg_rdata[ST_OWN_VALID_BIT] <= (own_d != ID_NONE) && (own_d <= top_d);
          reg_rdata[ST_INITIATOR_BIT] <= (own_d == top_d);
          reg_rdata[ST_RSVD_RATE_BIT] <= rsvd_d;
          reg_rdata[ST_FAST_RATE_BIT] <= fast_d;
          reg_rdata[ST_DIAG_BIT]      <= !s_diag_n;
          reg_rdata[ST_PRESCALE_LSB+:3] <= presc_d;
          reg_rdata[ST_PAGE_LSB+:2]   <= page_d;
          reg_rdata[ST_TOP_LSB+:5]    <= top_d;
        end
        default:      reg_rdata <= 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence pw_started_s;
    (pw_state_q == PW_IDLE) && prio_wait_start && (own_d == 5'h1E);
  endsequence
  sequence tick_eight_s;
    !bit_tick [*7] ##1 (bit_tick || presc_age_q < 4'h8);
  endsequence
  // Watch-only counters for spans too long for a delay range
  logic [2:0]  presc_prev_q;
  logic [3:0]  presc_age_q;
  logic [15:0] pw_cyc_q;
  always_ff @(posedge clk_sys) begin
    presc_prev_q <= presc_d;
    presc_age_q  <= (reset || presc_d != presc_prev_q) ? 4'h0 : presc_age_q + 4'(presc_age_q != 4'hF);
    pw_cyc_q     <= (!reset && pw_state_q == PW_UNIT) ? pw_cyc_q + 16'h0001 : 16'h0000;
  end

  diag_top_force_a: assert property (!s_diag_n |=> top_node_id == ID_DIAG_TOP)
    else $error("top id not forced in diagnostic mode");
  top_source_a: assert property (s_diag_n && src_main |=> top_node_id == $past(top_q))
    else $error("top id not taken from register");
  page_map_a: assert property (page_d == PAGE_64 |=> page_bytes == 9'h040 && max_nodes == 5'h0F)
    else $error("page size decode wrong");
  own_valid_a: assert property (own_d == ID_NONE |=> !own_id_valid)
    else $error("own id zero flagged valid");
  initiator_flag_a: assert property (token_initiator |-> own_node_id == top_node_id)
    else $error("initiator without matching ids");
  target_limit_a: assert property (token_target_ok |-> $past(token_target_id) <= top_node_id)
    else $error("token target above top id");
  strobe_pol_a: assert property ($stable(strobe_sync) && s_strobe_pol |=> strobe_asserted == !$past(strobe_sync))
    else $error("strobe polarity wrong");
  strap_hold_a: assert property ($stable(strap_q))
    else $error("straps changed outside reset");
  rx2_idle_a: assert property (s_hub_n |=> port2_rx_data)
    else $error("port2 receive not idle with hub off");
  tx2_off_a: assert property (s_hub_n |=> port2_tx_enable == !s_tx_pol)
    else $error("port2 transmit active with hub off");
  tx1_pol_a: assert property (!port1_tx_req |=> port1_tx_enable == !s_tx_pol)
    else $error("port1 idle level wrong");
  rsvd_tick_a: assert property (rsvd_d |=> !bit_tick)
    else $error("tick on reserved prescale");
  tick_gap_a: assert property (bit_tick && presc_d == 3'h0 && $stable(presc_d) |=> tick_eight_s)
    else $error("divide by eight spacing wrong");
  prio_one_slot_a: assert property ((pw_state_q == PW_UNIT) && (own_d == 5'h1E) |-> pw_cyc_q < unit_len)
    else $error("one-slot priority wait too long");
  prio_len_a: assert property (pw_started_s ##1 (pw_state_q == PW_UNIT) |-> (pw_state_q != PW_DONE) [*2])
    else $error("priority wait ended too early");

endmodule : nss_strap_decoder

// ### verification/nss_board_model.sv
// Board-side model: strobe pin wiring and the second port's receive line.
// Assumes the bench drives a logical strobe request and a port 2 line level.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module nss_board_model (
  input  wire logic strobe_polarity_strap,
  input  wire logic strobe_active,
  input  wire logic hub_enable_n,
  input  wire logic rx2_level,
  output logic      host_data_strobe,
  output logic      port2_rx_in
);
  // Host drives the pin low-active when the polarity strap is high
  assign host_data_strobe = strobe_polarity_strap ? ~strobe_active : strobe_active;
  // Line held high while the hub is off, so no stray edges reach port 2
  assign port2_rx_in = hub_enable_n ? 1'b1 : rx2_level;
endmodule : nss_board_model

// ### verification/tb_node_setup_strap_decoder.sv
// Self-checking bench for the strap decoder, one task per scenario.
// Assumes the board model beside it and a shortened priority unit.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module tb_node_setup_strap_decoder;
  import nss_pkg::*;
  localparam int unsigned UNIT = 20; // Short unit keeps the wait scenario brief
  logic        clk_sys, reset, reg_wr, reg_rd, strobe_polarity_strap, diagnostic_strap_n;
  logic        line_code_bypass_n, hub_enable_n, optical_mode_n, tx_enable_polarity, host_data_strobe;
  logic        port2_rx_in, port1_tx_req, port2_tx_req, tx_pulse, prio_wait_start, strobe_act, rx2_lvl;
  logic        strobe_asserted, own_id_valid, token_initiator, token_target_ok, prio_wait_busy;
  logic        prio_wait_done, bit_tick, rate_reserved, cmi_bypass, hub_on, port2_rx_data;
  logic        port1_tx_enable, port2_tx_enable;
  logic [1:0]  page_size_strap;
  logic [2:0]  rate_prescale_strap;
  logic [3:0]  reg_addr;
  logic [4:0]  top_node_id_strap, own_node_id_strap, token_target_id, max_nodes, top_node_id, own_node_id;
  logic [8:0]  page_bytes;
  logic [15:0] reg_wdata, reg_rdata;
  int          num_errors = 0;
  int          tests_run = 0;

  // 40 MHz setting so prescale code 0 runs the fast rate
  nss_strap_decoder #(.MCLK_KHZ(40000), .PRIO_UNIT_CYCLES(UNIT)) DUT (
    .clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .strobe_polarity_strap, .page_size_strap, .top_node_id_strap, .own_node_id_strap,
    .diagnostic_strap_n, .rate_prescale_strap, .line_code_bypass_n, .hub_enable_n,
    .optical_mode_n, .tx_enable_polarity, .host_data_strobe, .port2_rx_in, .port1_tx_req,
    .port2_tx_req, .tx_pulse, .token_target_id, .prio_wait_start, .strobe_asserted,
    .page_bytes, .max_nodes, .top_node_id, .own_node_id, .own_id_valid, .token_initiator,
    .token_target_ok, .prio_wait_busy, .prio_wait_done, .bit_tick, .rate_reserved,
    .cmi_bypass, .hub_on, .port2_rx_data, .port1_tx_enable, .port2_tx_enable
  );
  nss_board_model BRD (.strobe_polarity_strap, .strobe_active(strobe_act), .hub_enable_n,
    .rx2_level(rx2_lvl), .host_data_strobe, .port2_rx_in);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers: stimulus tasks start on a rising edge, checks sit on falling edges
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : look
  // Called right after a rising edge; straps set in that step stay put
  task automatic do_reset;
    reset <= 1'b1;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    look(2);
  endtask : do_reset
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd
  // Cycles from one tick to the next, capped at 600
  task automatic tick_gap(output int n);
    n = 0;
    while (bit_tick !== 1'b1 && n < 600) begin
      @(negedge clk_sys);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (bit_tick !== 1'b1 && n < 600);
  endtask : tick_gap
  task automatic prio_len(input logic [4:0] own, output int n, output logic b);
    wr(REG_OWN_ID, 16'(own));
    look(3);
    @(posedge clk_sys);
    prio_wait_start <= 1'b1;
    @(posedge clk_sys);
    prio_wait_start <= 1'b0;
    n = 0;
    b = 1'b0;
    do begin
      @(negedge clk_sys);
      n++;
      b |= (prio_wait_busy === 1'b1);
    end while (prio_wait_done !== 1'b1 && n < 2000);
  endtask : prio_len

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_strobe;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk_sys);
      strobe_polarity_strap <= p[0];
      strobe_act <= 1'b0;
      do_reset();
      chk("strobe idle", 16'(strobe_asserted), 16'h0000);
      @(posedge clk_sys);
      strobe_act <= 1'b1;
      look(4);
      chk("strobe active", 16'(strobe_asserted), 16'h0001);
    end
    $display("strobe test done");
  endtask : t_strobe
  task automatic t_page;
    logic [15:0] v;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys);
      page_size_strap <= c[1:0];
      do_reset();
      @(posedge clk_sys);
      page_size_strap <= ~c[1:0]; // Late strap moves must not reach the output
      look(3);
      chk("page bytes", 16'(page_bytes), 16'(256 >> c));
      chk("max nodes", 16'(max_nodes), 16'((4 << c) - 1));
    end
    rd(REG_MODE, v);
    chk("mode reset", v, MODE_RST);
    rd(4'hF, v);
    chk("unmapped read", v, 16'h0000);
    wr(REG_PAGE, 16'h0001);
    look(3);
    chk("page from strap", 16'(page_bytes), 16'h0020);
    wr(REG_MODE, 16'h0200);
    look(3);
    chk("page from reg", 16'(page_bytes), 16'h0080);
    $display("page test done");
  endtask : t_page
  task automatic t_ids;
    @(posedge clk_sys);
    top_node_id_strap <= 5'h05;
    own_node_id_strap <= 5'h05;
    do_reset();
    chk("initiator", 16'(token_initiator), 16'h0001);
    chk("own valid", 16'(own_id_valid), 16'h0001);
    wr(REG_OWN_ID, 16'h0006);
    wr(REG_TOP_ID, 16'h0009);
    wr(REG_MODE, 16'h0080);
    look(3);
    chk("own from reg", 16'(own_node_id), 16'h0006);
    chk("top from strap", 16'(top_node_id), 16'h0005);
    chk("own above top", 16'(own_id_valid), 16'h0000);
    chk("not initiator", 16'(token_initiator), 16'h0000);
    wr(REG_MODE, 16'h0200);
    look(3);
    chk("own from strap", 16'(own_node_id), 16'h0005);
    chk("top from reg", 16'(top_node_id), 16'h0009);
    wr(REG_OWN_ID, 16'h0000);
    wr(REG_MODE, 16'h0280);
    look(3);
    chk("own zero", 16'(own_id_valid), 16'h0000);
    @(posedge clk_sys);
    diagnostic_strap_n <= 1'b0;
    do_reset();
    chk("diag top", 16'(top_node_id), 16'h001F);
    wr(REG_TOP_ID, 16'h0003);
    wr(REG_MODE, 16'h0200);
    look(3);
    chk("diag over reg", 16'(top_node_id), 16'h001F);
    $display("id test done");
  endtask : t_ids
  // Token targets 00, 05 and 06 against a top ID of 05; only 05 is accepted
  task automatic t_token;
    @(posedge clk_sys);
    diagnostic_strap_n <= 1'b1;
    do_reset();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      token_target_id <= 5'(i == 0 ? 0 : i + 4);
      look(2);
      chk("token target", 16'(token_target_ok), 16'(i == 1));
    end
    $display("token test done");
  endtask : t_token
  task automatic t_prio;
    int   n0, n1, n2;
    logic b;
    for (int r = 0; r < 2; r++) begin
      wr(REG_TOP_ID, 16'h001F);
      wr(REG_PRESCALE, 16'(r));
      wr(REG_MODE, 16'h0280);
      prio_len(5'h1F, n0, b);
      prio_len(5'h1E, n1, b);
      chk("prio one slot", 16'(n1 - n0), 16'(r == 1 ? UNIT : UNIT / 2));
      prio_len(5'h1D, n2, b);
      chk("prio busy", 16'(b), 16'h0001);
      chk("prio span", 16'(n2 - n0), 16'(r == 1 ? 2 * UNIT : UNIT));
    end
    $display("priority test done");
  endtask : t_prio
  task automatic t_rate;
    int          n;
    logic [15:0] v;
    wr(REG_MODE, 16'h0000);
    wr(REG_PRESCALE, 16'h0005);
    tick_gap(n);
    chk("tick from strap", 16'(n), 16'h0008);
    wr(REG_MODE, 16'h0200);
    for (int c = 0; c < 8; c++) begin
      wr(REG_PRESCALE, 16'(c));
      look(3);
      tick_gap(n);
      chk("tick period", 16'(n), 16'(c < 6 ? 8 << c : 600));
      chk("rate reserved", 16'(rate_reserved), 16'(c > 5));
    end
    rd(REG_STATUS, v);
    chk("status reserved", 16'(v[ST_RSVD_RATE_BIT]), 16'h0001);
    $display("rate test done");
  endtask : t_rate
  task automatic t_line;
    @(posedge clk_sys);
    line_code_bypass_n <= 1'b0;
    hub_enable_n <= 1'b0;
    tx_enable_polarity <= 1'b1;
    do_reset();
    look(3);
    chk("cmi bypass", 16'(cmi_bypass), 16'h0001);
    chk("hub on", 16'(hub_on), 16'h0001);
    chk("port2 rx", 16'(port2_rx_data), 16'h0000);
    @(posedge clk_sys);
    port1_tx_req <= 1'b1;
    port2_tx_req <= 1'b1;
    look(2);
    chk("tx1 plain", 16'(port1_tx_enable), 16'h0001);
    chk("tx2 plain", 16'(port2_tx_enable), 16'h0001);
    @(posedge clk_sys);
    line_code_bypass_n <= 1'b1;
    hub_enable_n <= 1'b1;
    optical_mode_n <= 1'b0;
    tx_enable_polarity <= 1'b0;
    do_reset();
    look(3);
    chk("cmi used", 16'(cmi_bypass), 16'h0000);
    chk("hub off", 16'(hub_on), 16'h0000);
    chk("port2 rx off", 16'(port2_rx_data), 16'h0001);
    chk("tx1 no pulse", 16'(port1_tx_enable), 16'h0001);
    chk("tx2 hub off", 16'(port2_tx_enable), 16'h0001);
    @(posedge clk_sys);
    tx_pulse <= 1'b1;
    look(2);
    chk("tx1 pulse", 16'(port1_tx_enable), 16'h0000);
    $display("line test done");
  endtask : t_line

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #400000;
    num_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end
  initial begin
    {reg_wr, reg_rd, port1_tx_req, port2_tx_req, tx_pulse, prio_wait_start, strobe_act, rx2_lvl,
     strobe_polarity_strap, reg_addr, reg_wdata, page_size_strap, rate_prescale_strap, token_target_id} = '0;
    {reset, diagnostic_strap_n, line_code_bypass_n, hub_enable_n, optical_mode_n, tx_enable_polarity} = '1;
    top_node_id_strap = 5'h05;
    own_node_id_strap = 5'h05;
    t_strobe();
    t_page();
    t_ids();
    t_token();
    t_prio();
    t_rate();
    t_line();
    tally_and_finish();
  end
endmodule : tb_node_setup_strap_decoder
